// [tb/rfs_stage_model.sv]
// Purpose: Power stage and monitor side of the supervisor pins.
// Assumes: Power-good has a pull-up; the fourth-phase input has none.
// Notes: A released fourth-phase line shows a changing pattern.
`timescale 1ns/1ps
module rfs_stage_model
(
  input wire logic core_clk,
  input wire logic power_good_out,
  input wire logic power_good_oe,
  input wire logic fourth_phase_drive,
  input wire logic fourth_phase_drive_oe,
  output logic power_good_in,
  output logic phase4_node
);
  logic last_q;
  initial last_q = 1'b0;
  assign power_good_in = power_good_oe ? power_good_out : 1'b1;
  assign phase4_node = fourth_phase_drive_oe ? fourth_phase_drive : ~last_q;
  always @(posedge core_clk)
    last_q <= phase4_node;
endmodule // rfs_stage_model

// [tb/rfs_supervisor_checker.sv]
// Purpose: Port-level assertions for the fault supervisor.
// Assumes: One clock domain, reset active high.
// Notes: Attached to every supervisor by bind.
`timescale 1ns/1ps
module rfs_supervisor_checker
  import rfs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_on,
  input wire logic phase4_driver_ready_input,
  input wire logic supply_up,
  input wire logic no_cpu_code,
  input wire logic family_sel,
  input wire logic [RFS_LVL_W-1:0] dac_target_level,
  input wire logic [RFS_LVL_W-1:0] sensed_output_level,
  input wire logic avg_overcurrent_flag,
  input wire logic [RFS_NCH-1:0] channel_overcurrent_flag,
  input wire logic softstart_run,
  input wire logic [RFS_NCH-1:0] high_side_gate,
  input wire logic [RFS_NCH-1:0] low_side_gate,
  input wire logic fourth_phase_drive,
  input wire logic fourth_phase_drive_oe,
  input wire logic power_good_oe
);
  logic en;
  logic ov_hit;
  logic ov_free;
  logic [15:0] lvl;
  assign en = chip_on && phase4_driver_ready_input && supply_up && !no_cpu_code;
  assign lvl = 16'(sensed_output_level);
  // Above both the default offset and the early floor, so any setting trips.
  assign ov_hit = !family_sel && en && lvl > RFS_OVP_FLOOR_FAM1_MV
    && lvl > 16'(dac_target_level) + RFS_OVP_OFS_DEF_MV;
  // At or below the lowest possible trip level, so no overvoltage can compete.
  assign ov_free = lvl <= 16'(dac_target_level) + RFS_OVP_OFS_ALT_MV;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  off_safe_a: assert property (!en ##1 !en |=> power_good_oe && high_side_gate == 3'h0
    && low_side_gate == 3'h0 && !fourth_phase_drive_oe)
    else $error("disabled outputs not safe");
  pg_low_a: assert property (!softstart_run ##1 !softstart_run |=> power_good_oe)
    else $error("power good released while stopped");
  oc_shut_a: assert property ($rose(avg_overcurrent_flag) && ov_free ##1 avg_overcurrent_flag
    && softstart_run |=>
    high_side_gate == 3'h0 && low_side_gate == 3'h0 && !fourth_phase_drive_oe
    && power_good_oe)
    else $error("overcurrent shutdown wrong");
  chan_limit_a: assert property ($past(channel_overcurrent_flag, 2) != 3'h0 |->
    (high_side_gate & $past(channel_overcurrent_flag, 2)) == 3'h0)
    else $error("limited channel high side on");
  ov_force_a: assert property ($rose(ov_hit) && softstart_run ##1 ov_hit |=>
    low_side_gate == 3'h7 && high_side_gate == 3'h0 && !fourth_phase_drive
    && fourth_phase_drive_oe && power_good_oe)
    else $error("overvoltage outputs wrong");
endmodule // rfs_supervisor_checker
bind rfs_supervisor rfs_supervisor_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .chip_on(chip_on),
  .phase4_driver_ready_input(phase4_driver_ready_input), .supply_up(supply_up),
  .no_cpu_code(no_cpu_code), .family_sel(family_sel), .dac_target_level(dac_target_level),
  .sensed_output_level(sensed_output_level), .avg_overcurrent_flag(avg_overcurrent_flag),
  .channel_overcurrent_flag(channel_overcurrent_flag), .softstart_run(softstart_run),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
  .fourth_phase_drive(fourth_phase_drive), .fourth_phase_drive_oe(fourth_phase_drive_oe),
  .power_good_oe(power_good_oe));

// [tb/testbench.sv]
// Purpose: Self-checking bench for the fault supervisor.
// Assumes: Shortened retry wait and blanking counts.
// Notes: Levels and settings are random from a fixed seed.
`timescale 1ns/1ps
module testbench
  import rfs_pkg::*;
;
  localparam int OC_W = 50;
  logic core_clk, sys_rst, psel, penable, pwrite, chip_on, phase4_driver_ready_input;
  logic supply_up, no_cpu_code, family_sel, threshold_select_pin, initial_delay_phase;
  logic first_ramp_phase, softstart_done, cpu_voltage_code_change, dac_settled, er, alt;
  logic avg_overcurrent_flag, fourth_phase_request, power_good_in, phase4_node, irq;
  logic pready, pslverr, softstart_run, fourth_phase_drive, fourth_phase_drive_oe;
  logic power_good_out, power_good_oe, dead_time_mode;
  logic [11:0] paddr, dac_target_level, sensed_output_level, dac, thr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] channel_overcurrent_flag, high_side_request, high_side_gate, low_side_gate;
  logic [2:0] freq_adjust;
  logic [4:0] c2;
  int n_fail, n_checks, cyc, n, ch;
  rfs_supervisor #(.OC_WAIT_CYCLES(OC_W), .VID_BLANK_CYCLES(10)) uut (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .chip_on(chip_on), .phase4_driver_ready_input(phase4_driver_ready_input),
    .supply_up(supply_up), .no_cpu_code(no_cpu_code), .family_sel(family_sel),
    .threshold_select_pin(threshold_select_pin), .initial_delay_phase(initial_delay_phase),
    .first_ramp_phase(first_ramp_phase), .softstart_done(softstart_done),
    .cpu_voltage_code_change(cpu_voltage_code_change), .dac_settled(dac_settled),
    .dac_target_level(dac_target_level), .sensed_output_level(sensed_output_level),
    .avg_overcurrent_flag(avg_overcurrent_flag), .softstart_run(softstart_run),
    .channel_overcurrent_flag(channel_overcurrent_flag), .low_side_gate(low_side_gate),
    .high_side_request(high_side_request), .fourth_phase_request(fourth_phase_request),
    .high_side_gate(high_side_gate), .fourth_phase_drive(fourth_phase_drive),
    .fourth_phase_drive_oe(fourth_phase_drive_oe), .power_good_in(power_good_in),
    .power_good_out(power_good_out), .power_good_oe(power_good_oe),
    .dead_time_mode(dead_time_mode), .freq_adjust(freq_adjust));
  rfs_stage_model u_stage (.core_clk(core_clk), .power_good_out(power_good_out),
    .power_good_oe(power_good_oe), .fourth_phase_drive(fourth_phase_drive),
    .fourth_phase_drive_oe(fourth_phase_drive_oe), .power_good_in(power_good_in),
    .phase4_node(phase4_node));
  always #50 core_clk = ~core_clk;
  function automatic logic [11:0] pct(input logic [11:0] d, input int t);
    return 12'((int'(d) * t) / 10);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic [2:0] e);
    apb(1'b0, RFS_STATUS_ADDR, 32'h0);
    chk(q[2:0], e);
  endtask
  task automatic done;
    softstart_done <= 1'b1;
    wc(1);
    softstart_done <= 1'b0;
    wc(3);
  endtask
  task automatic go_run;
    {chip_on, phase4_driver_ready_input, supply_up, no_cpu_code} <= 4'he;
    wc(3);
    st(3'h1);
    chk(power_good_in, 1'b0);
    done;
    st(3'h2);
    chk({power_good_out, power_good_in}, 2'h1);
  endtask
  // Finishes the current low stretch, sees a retry, then times one full wait.
  task automatic gap(output int k);
    int t;
    t = 0;
    while (softstart_run !== 1'b1 && ++t < 500) wc(1);
    while (softstart_run === 1'b1 && ++t < 500) wc(1);
    k = 0;
    while (softstart_run !== 1'b1 && ++t < 500)
    begin
      k++;
      wc(1);
    end
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial
  begin
    {core_clk, psel, penable, pwrite, paddr, pwdata, chip_on, phase4_driver_ready_input,
      supply_up, no_cpu_code, family_sel, threshold_select_pin, initial_delay_phase,
      first_ramp_phase, softstart_done, cpu_voltage_code_change, dac_settled,
      avg_overcurrent_flag, channel_overcurrent_flag, n_fail, n_checks, cyc} = '0;
    {fourth_phase_request, high_side_request, sys_rst} = 5'h1f;
    n = $urandom(6309);
    dac = 12'h320 + 12'($urandom % 32'h190);
    {dac_target_level, sensed_output_level} = {dac, dac};
    c2 = 5'($urandom);
    alt = 1'($urandom);
    wc(4);
    sys_rst <= 1'b0;
    apb(1'b0, RFS_CTRL2_ADDR, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 12'h020, 32'hffffffff);
    chk(er, 1'b1);
    st(3'h0);
    apb(1'b1, RFS_CTRL2_ADDR, {27'h0, c2});
    apb(1'b0, RFS_CTRL2_ADDR, 32'h0);
    chk(q, {27'h0, c2});
    chk({freq_adjust, dead_time_mode}, c2[4:1]);
    go_run;
    apb(1'b0, RFS_INT_STAT_ADDR, 32'h0);
    sensed_output_level <= pct(dac, 6) - 12'h1;
    wc(3);
    st(3'h2);
    chk({power_good_in, high_side_gate, irq}, 5'h0e);
    sensed_output_level <= pct(dac, 7);
    wc(3);
    chk(power_good_in, 1'b0);
    apb(1'b1, RFS_INT_MASK_ADDR, 32'hf);
    wc(2);
    chk(irq, 1'b1);
    apb(1'b0, RFS_INT_STAT_ADDR, 32'h0);
    chk(q[RFS_INT_UV_BIT], 1'b1);
    wc(2);
    chk(irq, 1'b0);
    sensed_output_level <= pct(dac, 7) + 12'h1;
    wc(3);
    chk(power_good_in, 1'b1);
    ch = $urandom % 3;
    channel_overcurrent_flag <= 3'h1 << ch;
    wc(8);
    chk(high_side_gate, 3'(~(3'h1 << ch)));
    chk(low_side_gate[ch], 1'b1);
    channel_overcurrent_flag <= 3'h0;
    wc(3);
    chk(high_side_gate, 3'h7);
    avg_overcurrent_flag <= 1'b1;
    wc(3);
    st(3'h4);
    chk({power_good_in, fourth_phase_drive_oe}, 2'h0);
    for (int i = 0; i < 2; i++)
    begin
      gap(n);
      chk(32'(n >= OC_W - 1 && n <= OC_W + 2), 32'h1);
    end
    avg_overcurrent_flag <= 1'b0;
    wc(OC_W + 8);
    go_run;
    for (int i = 0; i < 4; i++)
    begin
      {chip_on, phase4_driver_ready_input, supply_up, no_cpu_code} <= 4'he ^ (4'h8 >> i);
      wc(3);
      st(3'h0);
      chk(power_good_in, 1'b0);
      go_run;
    end
    {chip_on, initial_delay_phase} <= 2'h1;
    {dac_target_level, sensed_output_level} <= {12'h320, 12'h44c};
    wc(3);
    chip_on <= 1'b1;
    wc(4);
    st(3'h1);
    {initial_delay_phase, first_ramp_phase} <= 2'h1;
    wc(3);
    st(3'h1);
    first_ramp_phase <= 1'b0;
    sensed_output_level <= 12'h514;
    wc(3);
    st(3'h3);
    sensed_output_level <= 12'h320;
    chip_on <= 1'b0;
    wc(3);
    {chip_on, family_sel} <= 2'h3;
    sensed_output_level <= 12'h834;
    wc(4);
    st(3'h1);
    sensed_output_level <= 12'h320;
    done;
    cpu_voltage_code_change <= 1'b1;
    sensed_output_level <= 12'h500;
    wc(1);
    cpu_voltage_code_change <= 1'b0;
    wc(4);
    st(3'h2);
    dac_settled <= 1'b1;
    wc(1);
    dac_settled <= 1'b0;
    st(3'h2);
    wc(12);
    st(3'h3);
    {dac_target_level, sensed_output_level} <= {dac, dac};
    {chip_on, family_sel} <= 2'h0;
    wc(3);
    go_run;
    threshold_select_pin <= alt;
    thr = dac + ((alt | c2[0]) ? 12'h0af : 12'h0fa);
    sensed_output_level <= thr + 12'h1;
    wc(3);
    chk({low_side_gate, high_side_gate, phase4_node, fourth_phase_drive_oe, power_good_in},
      9'h1c2);
    sensed_output_level <= thr - 12'h64;
    wc(3);
    apb(1'b0, RFS_STATUS_ADDR, 32'h0);
    chk(q[4], 1'b1);
    sensed_output_level <= thr - 12'h65;
    wc(3);
    apb(1'b0, RFS_STATUS_ADDR, 32'h0);
    chk(q[4:0], 5'h03);
    sensed_output_level <= thr + 12'h1;
    wc(3);
    chk(low_side_gate, 3'h7);
    sensed_output_level <= dac;
    done;
    st(3'h3);
    chk(power_good_in, 1'b0);
    chip_on <= 1'b0;
    wc(3);
    st(3'h0);
    chip_on <= 1'b1;
    wc(3);
    st(3'h1);
    tally_and_finish;
  end
endmodule // testbench

// [verilog/rfs_pkg.sv]
// Purpose: Shared constants and types for the regulator fault supervisor.
// Assumes: Levels are carried as unsigned millivolt codes; clock is 10 MHz.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
package rfs_pkg;

  // Clock rate and timing figures.
  localparam int RFS_CLK_HZ = 10_000_000;
  localparam int RFS_OC_WAIT_MS = 12;
  localparam int RFS_OC_WAIT_CYC = RFS_OC_WAIT_MS * (RFS_CLK_HZ / 1000);
  localparam int RFS_VID_BLANK_US = 50;
  localparam int RFS_VID_BLANK_CYC = RFS_VID_BLANK_US * (RFS_CLK_HZ / 1_000_000);

  // Level widths and fixed levels in millivolts.
  localparam int RFS_LVL_W = 12;
  localparam int RFS_CALC_W = 16;
  localparam logic [15:0] RFS_OVP_OFS_DEF_MV = 16'h00fa;
  localparam logic [15:0] RFS_OVP_OFS_ALT_MV = 16'h00af;
  localparam logic [15:0] RFS_OVP_FLOOR_FAM1_MV = 16'h0500;
  localparam logic [15:0] RFS_OVP_FLOOR_FAM2_MV = 16'h0898;
  localparam logic [15:0] RFS_OVP_HYST_MV = 16'h0064;

  // Undervoltage assert at 60 percent and release at 70 percent, in tenths.
  localparam logic [3:0] RFS_UV_SET_TENTHS = 4'h6;
  localparam logic [3:0] RFS_UV_CLR_TENTHS = 4'h7;
  localparam logic [3:0] RFS_TENTHS_SCALE = 4'ha;

  // Comparator references, kept for documentation of the flag inputs (uA).
  localparam int RFS_AVG_OC_REF_UA = 125;
  localparam int RFS_CHAN_OC_REF_UA = 170;

  // Register map.
  localparam int RFS_NCH = 3;
  localparam logic [7:0] RFS_CTRL2_INDEX = 8'h01;
  localparam logic [11:0] RFS_CTRL2_ADDR = {2'b00, RFS_CTRL2_INDEX, 2'b00};
  localparam logic [11:0] RFS_STATUS_ADDR = 12'h008;
  localparam logic [11:0] RFS_INT_STAT_ADDR = 12'h00c;
  localparam logic [11:0] RFS_INT_MASK_ADDR = 12'h010;

  // Control register two fields.
  localparam int RFS_C2_OVP_ALT_BIT = 0;
  localparam int RFS_C2_DEADTIME_BIT = 1;
  localparam int RFS_C2_FREQ_LSB = 2;
  localparam int RFS_C2_FREQ_W = 3;
  localparam logic [7:0] RFS_CTRL2_RESET = 8'h00;
  localparam logic [7:0] RFS_CTRL2_MASK = 8'h1f;

  // Interrupt status bits.
  localparam int RFS_INT_W = 4;
  localparam int RFS_INT_OV_BIT = 0;
  localparam int RFS_INT_OC_BIT = 1;
  localparam int RFS_INT_UV_BIT = 2;
  localparam int RFS_INT_LIM_BIT = 3;
  localparam logic [3:0] RFS_INT_MASK_RESET = 4'h0;

  typedef enum logic [2:0] {
    RFS_OFF,
    RFS_SOFTSTART,
    RFS_RUN,
    RFS_OV_LATCH,
    RFS_OC_WAIT
  } rfs_state_t;

endpackage

// [verilog/rfs_supervisor.sv]
// Purpose: Fault supervisor for a multiphase step-down regulator controller.
// Assumes: All inputs are synchronous to core_clk; levels are millivolt codes.
// Notes: Power-good is open drain; the pin is pulled low while power_good_oe is high.
//
// What this block does
// - Power-good low in shutdown and soft-start.
// - Any fault or disable drops power-good.
// - Overvoltage or overcurrent latch off until soft-start.
// - Below sixty percent: power-good low only.
// - Power-good returns above seventy percent.
// - Overvoltage level from family, phase, settings.
// - First family floor early, then target plus offset.
// - Overvoltage: low sides high, fourth phase low.
// - Hold until 100mV below trip; repeat.
// - Overvoltage latch cleared only by disable.
// - Second family code change blanks overvoltage.
// - Averaged current over reference starts shutdown.
// - Overcurrent: all gates low, fourth phase floats.
// - Wait 12ms, then retry if enabled.
// - Trip, wait, retry repeats without limit.
// - Channel over limit: high low, low high.
// - Limited channel stays blocked until current drops.
// - Overvoltage alternate comes from register two or the select pin.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module rfs_supervisor
  import rfs_pkg::*;
#(
  parameter int OC_WAIT_CYCLES = RFS_OC_WAIT_CYC,
  parameter int VID_BLANK_CYCLES = RFS_VID_BLANK_CYC
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Enable conditions.
  input wire logic chip_on,
  input wire logic phase4_driver_ready_input,
  input wire logic supply_up,
  input wire logic no_cpu_code,
  // Operating family: low for the first, high for the second.
  input wire logic family_sel,
  input wire logic threshold_select_pin,
  // Soft-start sequencer state.
  input wire logic initial_delay_phase,
  input wire logic first_ramp_phase,
  input wire logic softstart_done,
  // Voltage code handling.
  input wire logic cpu_voltage_code_change,
  input wire logic dac_settled,
  input wire logic [RFS_LVL_W-1:0] dac_target_level,
  input wire logic [RFS_LVL_W-1:0] sensed_output_level,
  // Current comparators.
  input wire logic avg_overcurrent_flag,
  input wire logic [RFS_NCH-1:0] channel_overcurrent_flag,
  // Modulator requests.
  input wire logic [RFS_NCH-1:0] high_side_request,
  input wire logic fourth_phase_request,
  // Outputs to the power stage and system.
  output logic softstart_run,
  output logic [RFS_NCH-1:0] high_side_gate,
  output logic [RFS_NCH-1:0] low_side_gate,
  output logic fourth_phase_drive,
  output logic fourth_phase_drive_oe,
  input wire logic power_good_in,
  output logic power_good_out,
  output logic power_good_oe,
  output logic dead_time_mode,
  output logic [RFS_C2_FREQ_W-1:0] freq_adjust
);

  function automatic logic [RFS_CALC_W-1:0] max_mv(
    input logic [RFS_CALC_W-1:0] a,
    input logic [RFS_CALC_W-1:0] b
  );
    max_mv = (a > b) ? a : b;
  endfunction

  function automatic logic [RFS_CALC_W-1:0] scale_tenths(
    input logic [RFS_LVL_W-1:0] lvl,
    input logic [3:0] tenths
  );
    scale_tenths = RFS_CALC_W'({4'h0, lvl} * {12'h000, tenths});
  endfunction

  rfs_state_t state_q, state_d;

  // Sampled comparator flags and levels.
  logic avg_oc_q;
  logic [RFS_NCH-1:0] chan_oc_q;
  logic [RFS_LVL_W-1:0] lvl_q;
  logic [RFS_LVL_W-1:0] dac_q;

  logic uv_q;
  logic ov_force_q;
  logic [RFS_CALC_W-1:0] trip_thr_q;
  logic blank_q;
  logic blank_run_q;
  logic [15:0] blank_cnt_q;
  logic [16:0] wait_cnt_q;
  logic [7:0] ctrl2_q;
  logic [RFS_INT_W-1:0] int_q;
  logic [RFS_INT_W-1:0] mask_q;
  logic [RFS_NCH-1:0] lim_prev_q;
  logic uv_prev_q;

  // Enable chain.
  wire enabled = chip_on & phase4_driver_ready_input & supply_up & ~no_cpu_code;

  // Overvoltage threshold selection.
  wire ovp_alt = ctrl2_q[RFS_C2_OVP_ALT_BIT] | threshold_select_pin;
  wire [RFS_CALC_W-1:0] ovp_ofs = ovp_alt ? RFS_OVP_OFS_ALT_MV : RFS_OVP_OFS_DEF_MV;
  wire [RFS_CALC_W-1:0] ovp_base = RFS_CALC_W'({4'h0, dac_q} + ovp_ofs);
  wire in_ss = (state_q == RFS_SOFTSTART);
  wire fam1_early = ~family_sel & in_ss & (initial_delay_phase | first_ramp_phase);
  wire fam2_ss = family_sel & in_ss;
  wire [RFS_CALC_W-1:0] ovp_thr =
    fam2_ss ? max_mv(RFS_OVP_FLOOR_FAM2_MV, ovp_base) :
    fam1_early ? max_mv(RFS_OVP_FLOOR_FAM1_MV, ovp_base) :
    ovp_base;

  wire [RFS_CALC_W-1:0] lvl_w = {4'h0, lvl_q};
  wire ov_raw = (lvl_w > ovp_thr) & ~blank_q;
  wire ov_release = (lvl_w + RFS_OVP_HYST_MV) < trip_thr_q;
  wire powered = (state_q == RFS_SOFTSTART) | (state_q == RFS_RUN);
  wire ov_trip = ov_raw & powered;
  wire ov_retrip = ov_raw & (state_q == RFS_OV_LATCH) & ~ov_force_q;
  wire oc_trip = avg_oc_q & powered & ~ov_trip;

  // Undervoltage with hysteresis.
  wire [RFS_CALC_W-1:0] lvl_x10 = scale_tenths(lvl_q, RFS_TENTHS_SCALE);
  wire uv_set = lvl_x10 < scale_tenths(dac_q, RFS_UV_SET_TENTHS);
  wire uv_clr = lvl_x10 > scale_tenths(dac_q, RFS_UV_CLR_TENTHS);
  wire uv_d = uv_q ? ~uv_clr : uv_set;

  wire wait_done = (wait_cnt_q == 17'(OC_WAIT_CYCLES - 1));

  // Next state.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RFS_OFF:
        if (enabled)
          state_d = RFS_SOFTSTART;
      RFS_SOFTSTART, RFS_RUN:
        if (ov_trip)
          state_d = RFS_OV_LATCH;
        else if (oc_trip)
          state_d = RFS_OC_WAIT;
        else if (in_ss && softstart_done)
          state_d = RFS_RUN;
      RFS_OV_LATCH:
        state_d = RFS_OV_LATCH;
      RFS_OC_WAIT:
        if (wait_done)
          state_d = RFS_SOFTSTART;
      default:
        state_d = RFS_OFF;
    endcase
    if (!enabled)
      state_d = RFS_OFF;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= RFS_OFF;
    else
      state_q <= state_d;
  end

  // Input sampling on the core clock.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avg_oc_q <= 1'b0;
      chan_oc_q <= '0;
      lvl_q <= '0;
      dac_q <= '0;
    end
    else
    begin
      avg_oc_q <= avg_overcurrent_flag;
      chan_oc_q <= channel_overcurrent_flag;
      lvl_q <= sensed_output_level;
      dac_q <= dac_target_level;
    end
  end

  // Overvoltage force with the tripping threshold captured for release.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ov_force_q <= 1'b0;
      trip_thr_q <= '0;
    end
    else if (state_d == RFS_OFF)
      ov_force_q <= 1'b0;
    else if (ov_trip || ov_retrip)
    begin
      ov_force_q <= 1'b1;
      trip_thr_q <= ovp_thr;
    end
    else if (ov_force_q && ov_release)
      ov_force_q <= 1'b0;
  end

  // Second family code change blanking, ending a fixed time after settling.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      blank_q <= 1'b0;
      blank_run_q <= 1'b0;
      blank_cnt_q <= '0;
    end
    else if (family_sel && state_q == RFS_RUN && cpu_voltage_code_change)
    begin
      blank_q <= 1'b1;
      blank_run_q <= 1'b0;
      blank_cnt_q <= '0;
    end
    else if (state_q != RFS_RUN)
    begin
      blank_q <= 1'b0;
      blank_run_q <= 1'b0;
    end
    else if (blank_q && !blank_run_q && dac_settled)
      blank_run_q <= 1'b1;
    else if (blank_run_q)
    begin
      if (blank_cnt_q == 16'(VID_BLANK_CYCLES - 1))
      begin
        blank_q <= 1'b0;
        blank_run_q <= 1'b0;
      end
      else
        blank_cnt_q <= blank_cnt_q + 16'h0001;
    end
  end

  // Retry wait counter.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wait_cnt_q <= '0;
    else if (state_q == RFS_OC_WAIT)
      wait_cnt_q <= wait_cnt_q + 17'h00001;
    else
      wait_cnt_q <= '0;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      uv_q <= 1'b0;
    else
      uv_q <= uv_d;
  end

  // Gate drive selection.
  wire run_gates = powered & ~ov_trip & ~oc_trip;
  // Low sides go high on the trip cycle itself, not one cycle after the force flop.
  wire ov_now = ov_force_q | ov_trip | ov_retrip;
  wire [RFS_NCH-1:0] hs_d = run_gates ? (high_side_request & ~chan_oc_q) : '0;
  wire [RFS_NCH-1:0] ls_d =
    ov_now ? '1 :
    run_gates ? (~high_side_request | chan_oc_q) : '0;
  wire p4_oe_d = ov_now | run_gates;
  wire p4_d = run_gates & ~ov_force_q & fourth_phase_request;
  wire pg_d = (state_q == RFS_RUN) & enabled & ~uv_d & ~ov_raw & ~avg_oc_q & ~ov_force_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      high_side_gate <= '0;
      low_side_gate <= '0;
      fourth_phase_drive <= 1'b0;
      fourth_phase_drive_oe <= 1'b0;
      power_good_out <= 1'b0;
      power_good_oe <= 1'b1;
      softstart_run <= 1'b0;
    end
    else
    begin
      high_side_gate <= hs_d;
      low_side_gate <= ls_d;
      fourth_phase_drive <= p4_d;
      fourth_phase_drive_oe <= p4_oe_d;
      power_good_out <= 1'b0;
      power_good_oe <= ~pg_d;
      softstart_run <= (state_d == RFS_SOFTSTART) | (state_d == RFS_RUN);
    end
  end

  // APB slave: one wait state, answer on the second access cycle.
  wire apb_acc = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire hit_ctrl2 = (paddr == RFS_CTRL2_ADDR);
  wire hit_status = (paddr == RFS_STATUS_ADDR);
  wire hit_int = (paddr == RFS_INT_STAT_ADDR);
  wire hit_mask = (paddr == RFS_INT_MASK_ADDR);
  wire hit_any = hit_ctrl2 | hit_status | hit_int | hit_mask;
  wire wr_en = apb_done & pwrite & ~pslverr;
  wire int_rd_clr = apb_done & ~pwrite & hit_int;

  wire [31:0] status_word = {21'h000000, lim_prev_q, power_good_in, ~power_good_oe,
    blank_q, ov_force_q, uv_q, 3'(state_q)};
  wire [31:0] rd_word =
    hit_ctrl2 ? {24'h000000, ctrl2_q} :
    hit_status ? status_word :
    hit_int ? {28'h0000000, int_q} :
    hit_mask ? {28'h0000000, mask_q} : 32'h00000000;

  // Interrupt events; a new event wins over a read clear in the same cycle.
  wire [RFS_INT_W-1:0] ev;
  assign ev[RFS_INT_OV_BIT] = ov_trip | ov_retrip;
  assign ev[RFS_INT_OC_BIT] = oc_trip;
  assign ev[RFS_INT_UV_BIT] = uv_q & ~uv_prev_q;
  assign ev[RFS_INT_LIM_BIT] = |(chan_oc_q & ~lim_prev_q);
  wire [RFS_INT_W-1:0] int_d = (int_q & ~{RFS_INT_W{int_rd_clr}}) | ev;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~hit_any;
      prdata <= (apb_acc && !pwrite) ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl2_q <= RFS_CTRL2_RESET;
      mask_q <= RFS_INT_MASK_RESET;
    end
    else if (wr_en && hit_ctrl2)
      ctrl2_q <= pwdata[7:0] & RFS_CTRL2_MASK;
    else if (wr_en && hit_mask)
      mask_q <= pwdata[RFS_INT_W-1:0];
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_q <= '0;
      lim_prev_q <= '0;
      uv_prev_q <= 1'b0;
      irq <= 1'b0;
      dead_time_mode <= 1'b0;
      freq_adjust <= '0;
    end
    else
    begin
      int_q <= int_d;
      lim_prev_q <= chan_oc_q;
      uv_prev_q <= uv_q;
      irq <= |(int_d & mask_q);
      dead_time_mode <= ctrl2_q[RFS_C2_DEADTIME_BIT];
      freq_adjust <= ctrl2_q[RFS_C2_FREQ_LSB +: RFS_C2_FREQ_W];
    end
  end

endmodule // rfs_supervisor
